// ---- core/bcc_pkg.sv ----
/*
 * Package for the four-bridge current chopper: timing constants, register
 * map, state encoding and the structs that carry per-bridge signals.
 * Assumes a 100 MHz pclk; all time figures are turned into cycle counts here.
 */
package bcc_pkg;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 10;
  localparam int T_OFF_NS      = 8100;
  localparam int FD_PERMIL     = 301;
  localparam int T_BLANK_NS    = 1000;
  localparam int T_DEAD_NS     = 600;

  localparam logic [9:0] OFF_CYC   = 10'(T_OFF_NS / CLK_PERIOD_NS);
  localparam logic [9:0] FD_CYC    =
    10'((T_OFF_NS * FD_PERMIL / 1000) / CLK_PERIOD_NS);
  localparam logic [9:0] DEAD_CYC  = 10'(T_DEAD_NS / CLK_PERIOD_NS);
  localparam logic [6:0] BLANK_CYC = 7'(T_BLANK_NS / CLK_PERIOD_NS);

  // ****************************************************************
  // register map
  // ****************************************************************
  localparam logic [11:0] CTRL_OFS     = 12'h000;
  localparam logic [11:0] STATUS_OFS   = 12'h004;
  localparam logic [3:0]  CTRL_RST     = 4'hF;
  localparam int          TRIP_DIV     = 3;

  // ****************************************************************
  // drive patterns: {source_a, sink_a, source_b, sink_b}
  // ****************************************************************
  localparam logic [3:0] DRV_OFF  = 4'h0;
  localparam logic [3:0] DRV_DIAG = 4'h9;
  localparam logic [3:0] DRV_ANTI = 4'h6;
  localparam logic [3:0] DRV_SLOW = 4'h5;

  typedef enum logic [4:0] {
    ST_IDLE = 5'b0_0001,
    ST_ON   = 5'b0_0010,
    ST_FAST = 5'b0_0100,
    ST_DEAD = 5'b0_1000,
    ST_SLOW = 5'b1_0000
  } bcc_state_e_t;

  typedef struct packed {
    logic       current_level_bit0;
    logic       current_level_bit1;
    logic       direction;
    logic [9:0] current_reference_input;
    logic [9:0] sense_resistor_node;
    logic       short_detect;
  } bcc_bridge_in_t;

  typedef struct packed {
    bcc_state_e_t st;
    logic [9:0]   cnt;
    logic [6:0]   blank;
    logic         zc;
    logic [3:0]   drive;
  } bcc_bridge_t;

  typedef struct packed {
    bcc_bridge_t [3:0] br;
    logic              oc;
    logic [3:0]        en;
    logic [31:0]       prdata;
  } bcc_regs_t;

endpackage

// ---- core/bcc_top.sv ----
/*
 * Four full-bridge fixed off-time current choppers with mixed decay,
 * synchronous rectification, blanking and fault shutdown, plus an APB slave.
 * Assumes sense and reference arrive as digital codes synchronous to pclk.
 */
`timescale 1ns/1ps
module bcc_top #(
  parameter int NUM_BRIDGES = 4
) (
  input  wire logic                  pclk,           // 100 MHz clock
  input  wire logic                  presetn,        // async reset, low
  input  wire logic [11:0]           paddr,          // apb byte address
  input  wire logic                  psel,           // apb select
  input  wire logic                  penable,        // apb access phase
  input  wire logic                  pwrite,         // apb write
  input  wire logic [31:0]           pwdata,         // apb write data
  output logic [31:0]                prdata,         // apb read data
  output logic                       pready,         // apb ready
  output logic                       pslverr,        // apb error
  input  wire bcc_pkg::bcc_bridge_in_t [NUM_BRIDGES-1:0] bridge_in, // pins
  input  wire logic                  over_temp,      // junction too hot
  input  wire logic                  gate_supply_low, // reservoir low
  input  wire logic                  supply_lockout, // power-up lockout
  input  wire logic                  load_supply_ok, // load supply present
  output logic [NUM_BRIDGES-1:0][3:0] gate_drive     // src_a,snk_a,src_b,snk_b
);

  // ****************************************************************
  // decoding helpers
  // ****************************************************************
  function automatic logic level_off(input logic b0, input logic b1);
    return b0 & b1;
  endfunction

  function automatic logic [9:0] trip_level(input logic b0, input logic b1,
                                            input logic [9:0] ref_code);
    logic [9:0] full;
    full = 10'(ref_code / bcc_pkg::TRIP_DIV);
    unique case ({b1, b0})
      2'b00:   return full;
      2'b01:   return 10'((20'(full) * 20'd2) / 20'd3);
      2'b10:   return 10'(full / bcc_pkg::TRIP_DIV);
      default: return 10'h3FF;
    endcase
  endfunction

  function automatic logic [3:0] drive_of(input bcc_pkg::bcc_state_e_t st,
                                          input logic dir, input logic zc);
    unique case (st)
      bcc_pkg::ST_ON:   return dir ? bcc_pkg::DRV_DIAG : bcc_pkg::DRV_ANTI;
      bcc_pkg::ST_FAST: return zc ? bcc_pkg::DRV_OFF :
                          (dir ? bcc_pkg::DRV_ANTI : bcc_pkg::DRV_DIAG);
      bcc_pkg::ST_SLOW: return zc ? bcc_pkg::DRV_OFF : bcc_pkg::DRV_SLOW;
      default:          return bcc_pkg::DRV_OFF;
    endcase
  endfunction

  function automatic logic addr_mapped(input logic [11:0] a);
    return (a == bcc_pkg::CTRL_OFS) || (a == bcc_pkg::STATUS_OFS);
  endfunction

  // ****************************************************************
  // state
  // ****************************************************************
  bcc_pkg::bcc_regs_t s;
  bcc_pkg::bcc_regs_t next_s;
  logic               fault_any;
  logic [3:0]         short_any;
  logic [3:0]         on_vec;
  logic [3:0]         decay_vec;

  always_comb begin
    fault_any = supply_lockout | over_temp | gate_supply_low | s.oc;
    for (int k = 0; k < NUM_BRIDGES; k++) begin
      short_any[k] = bridge_in[k].short_detect;
      on_vec[k]    = (s.br[k].st == bcc_pkg::ST_ON);
      decay_vec[k] = (s.br[k].st != bcc_pkg::ST_ON) &&
                     (s.br[k].st != bcc_pkg::ST_IDLE);
    end
  end

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    logic       dis;
    logic       trip;
    logic [9:0] thr;
    dis    = 1'b0;
    trip   = 1'b0;
    thr    = '0;
    next_s = s;
    // set wins over the supply-cycle clear
    next_s.oc = (s.oc & load_supply_ok) | (|short_any);
    for (int i = 0; i < NUM_BRIDGES; i++) begin
      thr  = trip_level(bridge_in[i].current_level_bit0,
                        bridge_in[i].current_level_bit1,
                        bridge_in[i].current_reference_input);
      trip = bridge_in[i].sense_resistor_node >= thr;
      dis  = fault_any | ~s.en[i] | (|short_any) |
             level_off(bridge_in[i].current_level_bit0,
                       bridge_in[i].current_level_bit1);
      unique case (s.br[i].st)
        bcc_pkg::ST_IDLE: begin
          next_s.br[i].st    = bcc_pkg::ST_ON;
          next_s.br[i].blank = bcc_pkg::BLANK_CYC;
          next_s.br[i].cnt   = '0;
        end
        bcc_pkg::ST_ON: begin
          if (s.br[i].blank != '0) begin
            next_s.br[i].blank = 7'(s.br[i].blank - 7'd1);
          end else if (trip) begin
            next_s.br[i].st  = bcc_pkg::ST_FAST;
            next_s.br[i].cnt = '0;
            next_s.br[i].zc  = 1'b0;
          end
        end
        bcc_pkg::ST_FAST: begin
          next_s.br[i].cnt = 10'(s.br[i].cnt + 10'd1);
          if (s.br[i].cnt == 10'(bcc_pkg::FD_CYC - 10'd1)) begin
            next_s.br[i].st = bcc_pkg::ST_DEAD;
          end
        end
        bcc_pkg::ST_DEAD: begin
          next_s.br[i].cnt = 10'(s.br[i].cnt + 10'd1);
          if (s.br[i].cnt ==
              10'(bcc_pkg::FD_CYC + bcc_pkg::DEAD_CYC - 10'd1)) begin
            next_s.br[i].st = bcc_pkg::ST_SLOW;
          end
        end
        bcc_pkg::ST_SLOW: begin
          next_s.br[i].cnt = 10'(s.br[i].cnt + 10'd1);
          if (s.br[i].cnt == 10'(bcc_pkg::OFF_CYC - 10'd1)) begin
            next_s.br[i].st    = bcc_pkg::ST_ON;
            next_s.br[i].cnt   = '0;
            next_s.br[i].blank = bcc_pkg::BLANK_CYC;
            next_s.br[i].zc    = 1'b0;
          end
        end
        default: next_s.br[i].st = bcc_pkg::ST_IDLE;
      endcase
      // zero current ends rectification for the rest of the interval
      if (((s.br[i].st == bcc_pkg::ST_FAST) ||
           (s.br[i].st == bcc_pkg::ST_SLOW)) &&
          (bridge_in[i].sense_resistor_node == '0)) begin
        next_s.br[i].zc = 1'b1;
      end
      if (dis) begin
        next_s.br[i].st    = bcc_pkg::ST_IDLE;
        next_s.br[i].cnt   = '0;
        next_s.br[i].blank = '0;
        next_s.br[i].zc    = 1'b0;
      end
      next_s.br[i].drive = drive_of(next_s.br[i].st,
                                    bridge_in[i].direction,
                                    next_s.br[i].zc);
    end
    // ***** apb *****
    if (psel && penable && pwrite && (paddr == bcc_pkg::CTRL_OFS)) begin
      next_s.en = pwdata[3:0];
    end
    if (psel && !penable) begin
      unique case (paddr)
        bcc_pkg::CTRL_OFS:   next_s.prdata = {28'h000_0000, s.en};
        bcc_pkg::STATUS_OFS: next_s.prdata = {20'h0_0000, decay_vec, on_vec,
                                              supply_lockout, gate_supply_low,
                                              over_temp, s.oc};
        default:             next_s.prdata = 32'h0000_0000;
      endcase
    end
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '{br: '{default: '{st: bcc_pkg::ST_IDLE, cnt: 10'h000,
                               blank: 7'h00, zc: 1'b0, drive: 4'h0}},
             oc: 1'b0, en: bcc_pkg::CTRL_RST, prdata: 32'h0000_0000};
    end else begin
      s <= next_s;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~addr_mapped(paddr);
  assign prdata  = s.prdata;

  always_comb begin
    for (int j = 0; j < NUM_BRIDGES; j++) begin
      gate_drive[j] = s.br[j].drive;
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  for (genvar g = 0; g < NUM_BRIDGES; g++) begin : g_chk
    logic [9:0] thr_g;
    logic       dis_g;
    assign thr_g = trip_level(bridge_in[g].current_level_bit0,
                              bridge_in[g].current_level_bit1,
                              bridge_in[g].current_reference_input);
    assign dis_g = fault_any | ~s.en[g] | (|short_any) |
                   (bridge_in[g].current_level_bit0 &
                    bridge_in[g].current_level_bit1);

    a_trip_to_fast: assert property (
      @(posedge pclk) disable iff (!presetn)
      (s.br[g].st == bcc_pkg::ST_ON) && (s.br[g].blank == '0) && !dis_g &&
      (bridge_in[g].sense_resistor_node >= thr_g)
      |=> (s.br[g].st == bcc_pkg::ST_FAST) && !s.br[g].zc &&
          (gate_drive[g] == ($past(bridge_in[g].direction) ?
                             bcc_pkg::DRV_ANTI : bcc_pkg::DRV_DIAG)))
      else $error("trip did not start off-interval");

    a_blank_hold: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(s.br[g].st == bcc_pkg::ST_ON) && !dis_g
      |-> (s.br[g].blank == bcc_pkg::BLANK_CYC))
      else $error("blanking not started on switch");

    a_fast_len: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(s.br[g].st == bcc_pkg::ST_FAST)
      |-> (s.br[g].cnt == 10'h000))
      else $error("fast decay did not start at zero");

    a_fast_end: assert property (@(posedge pclk) disable iff (!presetn)
      (s.br[g].st == bcc_pkg::ST_FAST) && !dis_g &&
      (s.br[g].cnt == 10'(bcc_pkg::FD_CYC - 10'd1))
      |=> (s.br[g].st == bcc_pkg::ST_DEAD))
      else $error("fast decay length wrong");

    a_dead_off: assert property (@(posedge pclk) disable iff (!presetn)
      (s.br[g].st == bcc_pkg::ST_DEAD) |-> (gate_drive[g] == 4'h0))
      else $error("drivers on during dead time");

    a_off_end: assert property (@(posedge pclk) disable iff (!presetn)
      (s.br[g].st == bcc_pkg::ST_SLOW) && !dis_g &&
      (s.br[g].cnt == 10'(bcc_pkg::OFF_CYC - 10'd1))
      |=> (s.br[g].st == bcc_pkg::ST_ON) &&
          (s.br[g].blank == bcc_pkg::BLANK_CYC))
      else $error("off-interval did not end at its length");

    a_slow_sync: assert property (@(posedge pclk) disable iff (!presetn)
      (s.br[g].st == bcc_pkg::ST_SLOW) && !s.br[g].zc
      |-> (gate_drive[g] == bcc_pkg::DRV_SLOW))
      else $error("slow decay without rectification");

    a_zero_cut: assert property (@(posedge pclk) disable iff (!presetn)
      (s.br[g].st == bcc_pkg::ST_SLOW) && !dis_g &&
      (bridge_in[g].sense_resistor_node == '0) &&
      (s.br[g].cnt != 10'(bcc_pkg::OFF_CYC - 10'd1))
      |=> (gate_drive[g] == 4'h0))
      else $error("rectification kept after zero current");

    a_fault_off: assert property (@(posedge pclk) disable iff (!presetn)
      (over_temp || gate_supply_low || supply_lockout) |=>
      (gate_drive[g] == 4'h0) && (s.br[g].st == bcc_pkg::ST_IDLE))
      else $error("outputs on during fault");

    a_level_off: assert property (@(posedge pclk) disable iff (!presetn)
      bridge_in[g].current_level_bit0 && bridge_in[g].current_level_bit1
      |=> (gate_drive[g] == 4'h0))
      else $error("bridge on at zero level");

    a_on_diag: assert property (@(posedge pclk) disable iff (!presetn)
      (s.br[g].st == bcc_pkg::ST_ON)
      |-> (gate_drive[g] == ($past(bridge_in[g].direction) ?
                             bcc_pkg::DRV_DIAG : bcc_pkg::DRV_ANTI)))
      else $error("on-phase drives wrong diagonal");

    a_rect_fast: assert property (@(posedge pclk) disable iff (!presetn)
      (s.br[g].st == bcc_pkg::ST_FAST) && !s.br[g].zc
      |-> (gate_drive[g] == ($past(bridge_in[g].direction) ?
                             bcc_pkg::DRV_ANTI : bcc_pkg::DRV_DIAG)))
      else $error("fast decay without rectification");

    a_blank_mask: assert property (@(posedge pclk) disable iff (!presetn)
      (s.br[g].st == bcc_pkg::ST_ON) && (s.br[g].blank != '0) && !dis_g
      |=> (s.br[g].st == bcc_pkg::ST_ON))
      else $error("comparator acted during blanking");

    a_dead_start: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(s.br[g].st == bcc_pkg::ST_DEAD)
      |-> ($past(s.br[g].st) == bcc_pkg::ST_FAST))
      else $error("dead time not entered from fast decay");

    a_dead_end: assert property (@(posedge pclk) disable iff (!presetn)
      (s.br[g].st == bcc_pkg::ST_DEAD) && !dis_g &&
      (s.br[g].cnt == 10'(bcc_pkg::FD_CYC + bcc_pkg::DEAD_CYC - 10'd1))
      |=> (s.br[g].st == bcc_pkg::ST_SLOW))
      else $error("dead time length wrong");

    a_slow_start: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(s.br[g].st == bcc_pkg::ST_SLOW)
      |-> ($past(s.br[g].st) == bcc_pkg::ST_DEAD))
      else $error("slow decay entered without dead time");

    a_zc_fast: assert property (@(posedge pclk) disable iff (!presetn)
      (s.br[g].st == bcc_pkg::ST_FAST) && !dis_g &&
      (bridge_in[g].sense_resistor_node == '0)
      |=> s.br[g].zc)
      else $error("zero current missed in fast decay");

    a_oc_off: assert property (@(posedge pclk) disable iff (!presetn)
      s.oc |-> (gate_drive[g] == 4'h0))
      else $error("outputs on with overcurrent latched");

    a_idle_off: assert property (@(posedge pclk) disable iff (!presetn)
      (s.br[g].st == bcc_pkg::ST_IDLE) |-> (gate_drive[g] == 4'h0))
      else $error("drivers on while bridge idle");
  end

  a_short_latch: assert property (@(posedge pclk) disable iff (!presetn)
    (|short_any) |=> s.oc ##1 (s.oc || !$past(load_supply_ok)))
    else $error("short did not latch fault");

  a_oc_sticky: assert property (@(posedge pclk) disable iff (!presetn)
    s.oc && load_supply_ok |=> s.oc)
    else $error("overcurrent fault cleared without supply cycle");

endmodule // bcc_top

// ---- verif/bcc_winding_model.sv ----
/*
 * Winding model for the chopper bench: per bridge, current rises one code
 * a cycle on the diagonal driven first, falls at half rate on the opposite diagonal, holds in slow decay, falls otherwise.
 * Assumes gate drive codes {src_a, snk_a, src_b, snk_b} from bcc_top.
 */
`timescale 1ns/1ps
module bcc_winding_model (
  input  wire logic            pclk,   // bench clock
  input  wire logic [3:0][3:0] drive,  // gate drive per bridge
  output logic      [3:0][9:0] sense   // sense code per bridge
);
  // ****************************************************************
  // winding current
  // ****************************************************************
  logic [3:0][3:0] fwd;
  logic            half;

  initial begin
    sense = '0;
    fwd   = '0;
    half  = 1'b0;
  end

  always @(posedge pclk) begin
    half <= ~half;
    for (int i = 0; i < 4; i++) begin
      if (drive[i] != 4'h9 && drive[i] != 4'h6) begin
        fwd[i] <= 4'h0;
        if (drive[i] != 4'h5 && sense[i] != 10'h000)
          sense[i] <= sense[i] - 10'h001;
      end else if (fwd[i] == 4'h0 || fwd[i] == drive[i]) begin
        // diagonal that pushes current up the winding
        fwd[i] <= drive[i];
        if (sense[i] != 10'h3FF) sense[i] <= sense[i] + 10'h001;
      end else if (half && sense[i] != 10'h000) begin
        // opposite diagonal returns energy: current falls at half rate
        sense[i] <= sense[i] - 10'h001;
      end
    end
  end
endmodule // bcc_winding_model

// ---- verif/test_bridge_current_chopper_control.sv ----
/*
 * Bench for bcc_top: cycle model of the choppers and registers, compared
 * with every gate drive and every apb answer.
 * Assumes bcc_winding_model supplies the sense codes.
 */
`timescale 1ns/1ps
module test_bridge_current_chopper_control;
  // ****************************************************************
  // signals
  // ****************************************************************
  localparam logic [31:0] SEQ = 32'h901B_901B;
  logic                          pclk, presetn, psel, penable, pwrite;
  logic [11:0]                   paddr;
  logic [31:0]                   pwdata, prdata, mrd, lf;
  logic                          pready, pslverr, over_temp;
  logic                          gate_supply_low, supply_lockout;
  logic                          load_supply_ok;
  bcc_pkg::bcc_bridge_in_t [3:0] bridge_in;
  logic [3:0][3:0]               gate_drive;
  logic [3:0][9:0]               sense, ref_code;
  logic [3:0]                    lvl_b0, lvl_b1, dir, shorted;
  int                            err_total, n_compared, en_m, oc_m;
  int                            st[4], cnt[4], blk[4], zc[4], drv[4];

  bcc_top #(.NUM_BRIDGES(4)) dut (.pclk, .presetn, .paddr, .psel, .penable,
    .pwrite, .pwdata, .prdata, .pready, .pslverr, .bridge_in, .over_temp,
    .gate_supply_low, .supply_lockout, .load_supply_ok, .gate_drive);
  bcc_winding_model wind (.pclk, .drive(gate_drive), .sense);

  always_comb
    for (int i = 0; i < 4; i++)
      bridge_in[i] = '{lvl_b0[i], lvl_b1[i], dir[i], ref_code[i], sense[i],
                       shorted[i]};

  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic [31:0] nxt(logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction

  function automatic int thr(int i);
    int f;
    f = ref_code[i] / 3;
    case ({lvl_b1[i], lvl_b0[i]})
      2'b01:   return f * 2 / 3;
      2'b10:   return f / 3;
      default: return f;
    endcase
  endfunction

  function automatic logic [31:0] rd_m(logic [11:0] a);
    logic [31:0] r;
    r = '0;
    if (a == bcc_pkg::CTRL_OFS) r = en_m;
    if (a == bcc_pkg::STATUS_OFS) begin
      r[3:0] = {supply_lockout, gate_supply_low, over_temp, oc_m[0]};
      for (int i = 0; i < 4; i++) begin
        r[4 + i] = st[i] == 1;
        r[8 + i] = st[i] > 1;
      end
    end
    return r;
  endfunction

  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic apb(logic [11:0] a, logic w, logic [31:0] d, logic e);
    @(posedge pclk);
    psel <= 1;
    penable <= 0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    @(posedge pclk);
    while (!pready) @(posedge pclk);
    chk("pready", pready, 1'b1);
    chk("pslverr", pslverr, e);
    if (!w) chk("prdata", prdata, mrd);
    psel <= 0;
    penable <= 0;
  endtask

  task tally_and_finish;
    if (err_total == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // ****************************************************************
  // reference model
  // ****************************************************************
  always @(posedge pclk or negedge presetn) begin : model
    int t, n, dg;
    logic halt;
    if (!presetn) begin
      en_m = 15;
      oc_m = 0;
      mrd = '0;
      foreach (st[i]) st[i] = 0;
      foreach (drv[i]) drv[i] = 0;
    end else begin
      if (psel && !penable) mrd = rd_m(paddr);
      halt = over_temp | gate_supply_low | supply_lockout | oc_m[0];
      for (int i = 0; i < 4; i++) begin
        t = thr(i);
        dg = dir[i] ? 9 : 6;
        n = cnt[i] + 1;
        if (halt || (|shorted) || !en_m[i] || (lvl_b0[i] && lvl_b1[i])) begin
          st[i] = 0;
          drv[i] = 0;
        end else if (st[i] == 0 || (st[i] > 1 && n == 810)) begin
          st[i] = 1;
          blk[i] = 100;
          drv[i] = dg;
        end else if (st[i] == 1) begin
          drv[i] = dg;
          if (blk[i] > 0) blk[i]--;
          else if (sense[i] >= t) begin
            st[i] = 2;
            cnt[i] = 0;
            zc[i] = 0;
            drv[i] = 15 - dg;
          end
        end else begin
          if (sense[i] == 0 && st[i] != 3) zc[i] = 1;
          cnt[i] = n;
          st[i] = n >= 303 ? 4 : n >= 243 ? 3 : 2;
          drv[i] = (st[i] == 3 || zc[i]) ? 0 : st[i] == 4 ? 5 : 15 - dg;
        end
      end
      if (psel && penable && pwrite && paddr == bcc_pkg::CTRL_OFS)
        en_m = pwdata[3:0];
      oc_m = (|shorted) | (oc_m[0] & load_supply_ok);
    end
  end

  always @(negedge pclk)
    for (int i = 0; i < 4; i++)
      if (presetn) chk("drive", gate_drive[i], drv[i]);

  // ****************************************************************
  // stimulus
  // ****************************************************************
  initial begin
    pclk = 0;
    forever #5 pclk = ~pclk;
  end

  initial begin
    #600_000;
    err_total++;
    tally_and_finish();
  end

  initial begin
    int k;
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {over_temp, gate_supply_low, supply_lockout, shorted, dir} = '0;
    {lvl_b0, lvl_b1, ref_code} = '0;
    load_supply_ok = 1;
    err_total = 0;
    n_compared = 0;
    lf = 32'hd0f9_0e5a;
    repeat (2) @(posedge pclk);
    presetn <= 1;
    apb(bcc_pkg::CTRL_OFS, 0, 0, 0);
    for (int r = 0; r < 28; r++) begin
      for (int i = 0; i < 4; i++) begin
        lf = nxt(lf);
        k = (r + 4 * i) % 16;
        ref_code[i] <= 10'h12C + lf[8:0];
        if (r < 16) begin
          {lvl_b1[i], lvl_b0[i]} <= SEQ[2 * k +: 2];
          dir[i] <= (k < 8) ^ i[0];
        end else begin
          {lvl_b1[i], lvl_b0[i]} <= lf[11:10];
          dir[i] <= lf[9];
        end
      end
      repeat (r < 16 ? 900 : 1700) @(posedge pclk);
      apb(bcc_pkg::STATUS_OFS, 0, 0, 0);
    end
    {lvl_b0, lvl_b1} <= '0;
    for (int f = 0; f < 3; f++) begin
      {supply_lockout, gate_supply_low, over_temp} <= 3'(1 << f);
      repeat (300) @(posedge pclk);
      apb(bcc_pkg::STATUS_OFS, 0, 0, 0);
      {supply_lockout, gate_supply_low, over_temp} <= '0;
      repeat (1000) @(posedge pclk);
    end
    shorted[2] <= 1;
    repeat (3) @(posedge pclk);
    shorted <= '0;
    repeat (200) @(posedge pclk);
    apb(bcc_pkg::CTRL_OFS, 1, 32'h0000_000F, 0);
    apb(bcc_pkg::STATUS_OFS, 0, 0, 0);
    load_supply_ok <= 0;
    repeat (2) @(posedge pclk);
    load_supply_ok <= 1;
    repeat (1000) @(posedge pclk);
    apb(bcc_pkg::CTRL_OFS, 1, 32'h0000_0005, 0);
    repeat (1000) @(posedge pclk);
    apb(bcc_pkg::STATUS_OFS, 1, 32'hFFFF_FFFF, 0);
    apb(bcc_pkg::STATUS_OFS, 0, 0, 0);
    apb(12'h008, 0, 0, 1);
    apb(12'h008, 1, 32'h0000_0003, 1);
    apb(bcc_pkg::CTRL_OFS, 0, 0, 0);
    presetn <= 0;
    repeat (2) @(posedge pclk);
    presetn <= 1;
    apb(bcc_pkg::CTRL_OFS, 0, 0, 0);
    repeat (1000) @(posedge pclk);
    tally_and_finish();
  end
endmodule // test_bridge_current_chopper_control
